// >>> logic/ocdp_pkg.sv
// Package with register map, field layout, reset values and state codes for the output clock path.
package ocdp_pkg;
   localparam int OCDP_N_OUT = 3;
   localparam int OCDP_N_GP = 4;
   // Register byte offsets.
   localparam logic [7:0] OCDP_A_PH_CTRL_A = 8'h00;
   localparam logic [7:0] OCDP_A_PH_CTRL_B = 8'h04;
   localparam logic [7:0] OCDP_A_PH_STATUS = 8'h08;
   localparam logic [7:0] OCDP_A_DIV_EN = 8'h0C;
   localparam logic [7:0] OCDP_A_OUT_BASE = 8'h10;
   localparam logic [7:0] OCDP_A_OUT_LAST = 8'h3F;
   // Word index inside each 16-byte output block.
   localparam logic [1:0] OCDP_W_CFG1 = 2'h0;
   localparam logic [1:0] OCDP_W_CFG2 = 2'h1;
   localparam logic [1:0] OCDP_W_LOWDIV = 2'h2;
   localparam logic [1:0] OCDP_W_SHAPE = 2'h3;
   // Field positions in phase_ctrl_a.
   localparam int OCDP_B_MODE = 0;
   localparam int OCDP_B_ARM = 1;
   localparam int OCDP_B_TRIGGER_REQUEST = 2;
   localparam int OCDP_B_TRIGGER_INVERT = 3;
   localparam int OCDP_B_PRST = 4;
   // Field positions in output cfg2; the phase adjust enable sits in cfg1.
   localparam int OCDP_B_POL = 4;
   localparam int OCDP_B_DRV = 5;
   localparam int OCDP_B_LOW_DIV_SELECT = 8;
   localparam int OCDP_B_NLD = 9;
   localparam int OCDP_B_PHASE_ADJUST_EN = 7;
   // Output format codes.
   localparam logic [3:0] OCDP_F_OFF = 4'h0;
   localparam logic [3:0] OCDP_F_CML = 4'h1;
   localparam logic [3:0] OCDP_F_CML_HALF = 4'h2;
   localparam logic [3:0] OCDP_F_HSTL = 4'h3;
   localparam logic [3:0] OCDP_F_CMOS_P = 4'h4;
   localparam logic [3:0] OCDP_F_CMOS_SAME = 4'h5;
   localparam logic [3:0] OCDP_F_CMOS_INV = 4'h6;
   // Arm and trigger source codes; pins start at the given code.
   localparam logic [3:0] OCDP_ARM_BIT = 4'h1;
   localparam logic [3:0] OCDP_ARM_GP0 = 4'h2;
   localparam logic [3:0] OCDP_TRG_BIT = 4'h0;
   localparam logic [3:0] OCDP_TRG_GP0 = 4'h1;
   // Reset values.
   localparam logic [31:0] OCDP_RST_WORD = 32'h0000_0000;
   localparam logic [3:0] OCDP_RST_ARM_SRC = 4'h1;
   // Mid divider limits in half periods of the post-divider input clock.
   localparam logic [7:0] OCDP_POS_ODD = 8'h7F;
   localparam logic [7:0] OCDP_POS_EVEN = 8'h80;
   typedef enum logic [1:0] {
      OCDP_IDLE = 2'b00,
      OCDP_ARMED = 2'b01,
      OCDP_BUSY = 2'b10
   } ocdp_state_t;
endpackage

// >>> logic/ocdp_top.sv
// Per-output clock path: format, dividers, duty shaping and phase machine behind AHB-Lite.
`timescale 1ns/1ps
module ocdp_top
   import ocdp_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [3:0] gp_pin,
   output logic [2:0] out_pos_pin,
   output logic [2:0] out_pos_oe,
   output logic [2:0] out_neg_pin,
   output logic [2:0] out_neg_oe,
   output logic [5:0] drive_strength,
   output logic [2:0] cml_half_swing,
   output logic [2:0] driver_low_power
);
   ////////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [4:0] ctrl_a_r;
   logic [7:0] ctrl_b_r;
   logic [2:0] div_en_r;
   logic [7:0] cfg1_r [OCDP_N_OUT];
   logic [9:0] cfg2_r [OCDP_N_OUT];
   logic [24:0] lowdiv_r [OCDP_N_OUT];
   logic [15:0] shape_r [OCDP_N_OUT];
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic prst_pulse;
   ocdp_state_t state_r;
   logic [2:0] pend_r;
   logic addr_ok;
   logic [1:0] out_idx;
   logic [31:0] rd_word;

   // An address phase is accepted whenever the slave is selected with a real transfer while hready is high.
   assign addr_ok = hsel && htrans[1] && hready;
   assign out_idx = 2'(haddr[5:4] - 2'h1);

   // Read mux for the address seen in the current address phase; unmapped reads give zero.
   always_comb begin
      rd_word = OCDP_RST_WORD;
      if (haddr[31:8] == 24'h00_0000) begin
         if (haddr[7:0] == OCDP_A_PH_CTRL_A) begin
            rd_word = {28'h000_0000, ctrl_a_r[3:0]};
         end else if (haddr[7:0] == OCDP_A_PH_CTRL_B) begin
            rd_word = {24'h00_0000, ctrl_b_r};
         end else if (haddr[7:0] == OCDP_A_PH_STATUS) begin
            rd_word = {30'h0000_0000, state_r == OCDP_BUSY, state_r == OCDP_ARMED};
         end else if (haddr[7:0] == OCDP_A_DIV_EN) begin
            rd_word = {29'h0000_0000, div_en_r};
         end else if (haddr[7:0] >= OCDP_A_OUT_BASE && haddr[7:0] <= OCDP_A_OUT_LAST) begin
            case (haddr[3:2])
               OCDP_W_CFG1: rd_word = {24'h00_0000, cfg1_r[out_idx]};
               OCDP_W_CFG2: rd_word = {22'h00_0000, cfg2_r[out_idx]};
               OCDP_W_LOWDIV: rd_word = {7'h00, lowdiv_r[out_idx]};
               default: rd_word = {16'h0000, shape_r[out_idx]};
            endcase
         end
      end
   end

   // Bus handshake: zero wait states, always OKAY, read data registered at the address phase.
   always_ff @(posedge clk) begin
      if (srst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= OCDP_RST_WORD;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else if (ce) begin
         wr_pend_r <= addr_ok && hwrite && haddr[31:8] == 24'h00_0000;
         wr_addr_r <= haddr[7:0];
         if (addr_ok && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   // Global control words; the phase reset bit is a write-only pulse.
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_a_r <= 5'h00;
         ctrl_b_r <= {4'h0, OCDP_RST_ARM_SRC};
         div_en_r <= 3'h0;
      end else if (ce) begin
         ctrl_a_r[OCDP_B_PRST] <= 1'b0;
         if (wr_pend_r && wr_addr_r == OCDP_A_PH_CTRL_A) begin
            ctrl_a_r <= hwdata[4:0];
         end
         if (wr_pend_r && wr_addr_r == OCDP_A_PH_CTRL_B) begin
            ctrl_b_r <= hwdata[7:0];
         end
         if (wr_pend_r && wr_addr_r == OCDP_A_DIV_EN) begin
            div_en_r <= hwdata[2:0];
         end
      end
   end
   assign prst_pulse = ctrl_a_r[OCDP_B_PRST];

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and arm/trigger event detection.
   logic [3:0] gp_s1_r;
   logic [3:0] gp_s2_r;
   logic [3:0] gp_s3_r;
   logic [3:0] gp_q_r;
   logic [3:0] gp_q_r_d;
   logic arm_bit_d_r;
   logic trg_lvl_d_r;
   logic arm_ev;
   logic trg_ev;
   logic trg_lvl;
   logic [3:0] arm_idx;
   logic [3:0] trg_idx;

   // Three stages; the filtered level follows only when stages two and three agree.
   always_ff @(posedge clk) begin
      if (srst) begin
         gp_s1_r <= 4'h0;
         gp_s2_r <= 4'h0;
         gp_s3_r <= 4'h0;
         gp_q_r <= 4'h0;
      end else if (ce) begin
         gp_s1_r <= gp_pin;
         gp_s2_r <= gp_s1_r;
         gp_s3_r <= gp_s2_r;
         gp_q_r <= (gp_s2_r & ~(gp_s2_r ^ gp_s3_r)) | (gp_q_r & (gp_s2_r ^ gp_s3_r));
      end
   end

   assign arm_idx = 4'(ctrl_b_r[3:0] - OCDP_ARM_GP0);
   assign trg_idx = 4'(ctrl_b_r[7:4] - OCDP_TRG_GP0);

   // Selected trigger level, inverted on request so one pin can arm and trigger.
   always_comb begin
      trg_lvl = 1'b0;
      if (ctrl_b_r[7:4] == OCDP_TRG_BIT) begin
         trg_lvl = ctrl_a_r[OCDP_B_TRIGGER_REQUEST];
      end else if (trg_idx < 4'(OCDP_N_GP)) begin
         trg_lvl = gp_q_r[trg_idx[1:0]];
      end
      trg_lvl = trg_lvl ^ ctrl_a_r[OCDP_B_TRIGGER_INVERT];
   end

   // Arm on a rising edge of the arm bit or a rising edge of the selected pin.
   always_comb begin
      arm_ev = 1'b0;
      if (ctrl_b_r[3:0] == OCDP_ARM_BIT) begin
         arm_ev = ctrl_a_r[OCDP_B_ARM] && !arm_bit_d_r;
      end else if (arm_idx < 4'(OCDP_N_GP)) begin
         arm_ev = gp_q_r[arm_idx[1:0]] && !gp_q_r_d[arm_idx[1:0]];
      end
   end
   assign trg_ev = trg_lvl && !trg_lvl_d_r;

   // Previous values for edge detection.
   always_ff @(posedge clk) begin
      if (srst) begin
         arm_bit_d_r <= 1'b0;
         trg_lvl_d_r <= 1'b0;
         gp_q_r_d <= 4'h0;
      end else if (ce) begin
         arm_bit_d_r <= ctrl_a_r[OCDP_B_ARM];
         trg_lvl_d_r <= trg_lvl;
         gp_q_r_d <= gp_q_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Phase machine: idle, armed awaiting trigger, busy until no output has a shift pending.
   logic trg_take;
   assign trg_take = state_r == OCDP_ARMED && trg_ev && ctrl_a_r[OCDP_B_MODE];

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= OCDP_IDLE;
      end else if (ce) begin
         case (state_r)
            OCDP_IDLE: begin
               if (arm_ev && !prst_pulse) begin
                  state_r <= OCDP_ARMED;
               end
            end
            OCDP_ARMED: begin
               if (prst_pulse) begin
                  state_r <= OCDP_IDLE;
               end else if (trg_take) begin
                  state_r <= OCDP_BUSY;
               end
            end
            OCDP_BUSY: begin
               if (pend_r == 3'h0) begin
                  state_r <= OCDP_IDLE;
               end
            end
            default: state_r <= OCDP_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-output registers, dividers and driver logic.
   genvar g;
   generate
      for (g = 0; g < OCDP_N_OUT; g++) begin : g_out
         logic sel;
         logic [6:0] m;
         logic [24:0] lr;
         logic [7:0] dc;
         logic signed [8:0] amt;
         logic signed [8:0] neg_lim;
         logic signed [8:0] pos_lim;
         logic signed [8:0] clamp;
         logic signed [8:0] extra_r;
         logic [8:0] mid_cnt_r;
         logic [8:0] ph_len;
         logic mid_r;
         logic run;
         logic [25:0] low_cnt_r;
         logic [25:0] low_div;
         logic [25:0] low_hi;
         logic low_r;
         logic pos_src;
         logic neg_src;
         logic [3:0] fmt;
         logic polarity_invert;

         assign sel = wr_pend_r && wr_addr_r[7:4] == 4'(g + 1);
         assign m = cfg1_r[g][6:0];
         assign lr = lowdiv_r[g];
         assign dc = shape_r[g][7:0];
         assign amt = $signed({shape_r[g][15], shape_r[g][15:8]});
         assign fmt = cfg2_r[g][3:0];
         assign polarity_invert = cfg2_r[g][OCDP_B_POL];
         assign run = div_en_r[g] && fmt != OCDP_F_OFF;

         // Per-output configuration words.
         always_ff @(posedge clk) begin
            if (srst) begin
               cfg1_r[g] <= 8'h00;
               cfg2_r[g] <= 10'h000;
               lowdiv_r[g] <= 25'h000_0000;
               shape_r[g] <= 16'h0000;
            end else if (ce && sel) begin
               case (wr_addr_r[3:2])
                  OCDP_W_CFG1: cfg1_r[g] <= hwdata[7:0];
                  OCDP_W_CFG2: cfg2_r[g] <= hwdata[9:0];
                  OCDP_W_LOWDIV: lowdiv_r[g] <= hwdata[24:0];
                  default: shape_r[g] <= hwdata[15:0];
               endcase
            end
         end

         // Amount limits in half periods, derived from the mid ratio parity.
         assign neg_lim = m[0] ? -$signed({2'b00, m - 7'h01}) : -$signed({2'b00, m - 7'h02});
         assign pos_lim = m[0] ? $signed({1'b0, OCDP_POS_ODD - {1'b0, m}})
                               : $signed({1'b0, OCDP_POS_EVEN - {1'b0, m}});
         assign clamp = (amt < neg_lim) ? neg_lim : ((amt > pos_lim) ? pos_lim : amt);

         // Pending shift is set by the trigger and wins over the take in the same cycle.
         always_ff @(posedge clk) begin
            if (srst) begin
               pend_r[g] <= 1'b0;
            end else if (ce) begin
               if (trg_take && cfg1_r[g][OCDP_B_PHASE_ADJUST_EN] && amt != 9'sd0 && m != 7'h00) begin
                  pend_r[g] <= 1'b1;
               end else if (!run || m == 7'h00 || (!mid_r && ph_len == mid_cnt_r + 9'h001)) begin
                  pend_r[g] <= 1'b0;
               end
            end
         end

         // Mid divider; clk ticks are half input periods, so ratio m+1 is high m+1 ticks.
         assign ph_len = 9'({2'b00, m} + 9'h001 + (mid_r ? 9'(extra_r) : 9'h000));
         always_ff @(posedge clk) begin
            if (srst || !run) begin
               mid_cnt_r <= 9'h000;
               mid_r <= 1'b0;
               extra_r <= 9'sd0;
            end else if (ce) begin
               if (m == 7'h00) begin
                  mid_r <= ~mid_r;
               end else if (mid_cnt_r + 9'h001 >= ph_len) begin
                  mid_cnt_r <= 9'h000;
                  mid_r <= ~mid_r;
                  extra_r <= (!mid_r && pend_r[g]) ? clamp : 9'sd0;
               end else begin
                  mid_cnt_r <= mid_cnt_r + 9'h001;
               end
            end
         end

         // Low divider counts mid edges, so odd ratios still give 50%.
         assign low_div = 26'({1'b0, lr} + 26'h000_0001);
         assign low_hi = (dc != 8'h00 && m != 7'h00 && lr > 25'h000_0001)
                         ? {17'h0_0000, dc, 1'b0} : low_div;
         always_ff @(posedge clk) begin
            if (srst || !run) begin
               low_cnt_r <= 26'h000_0000;
               low_r <= 1'b0;
            end else if (ce) begin
               if (mid_cnt_r + 9'h001 >= ph_len && m != 7'h00) begin
                  // Compared one bit wider so the largest ratio does not wrap to zero.
                  if ({1'b0, low_cnt_r} + 27'h000_0001 >= {low_div, 1'b0}) begin
                     low_cnt_r <= 26'h000_0000;
                     low_r <= 1'b1;
                  end else begin
                     low_cnt_r <= low_cnt_r + 26'h000_0001;
                     low_r <= (low_cnt_r + 26'h000_0001) < low_hi;
                  end
               end
            end
         end

         // Pin sources: low divider only when selected and mid ratio is nonzero.
         assign pos_src = (cfg2_r[g][OCDP_B_LOW_DIV_SELECT] && m != 7'h00) ? low_r : mid_r;
         assign neg_src = (cfg2_r[g][OCDP_B_NLD] && m != 7'h00) ? low_r : pos_src;

         // Driver flops: format, polarity and enable.
         always_ff @(posedge clk) begin
            if (srst) begin
               out_pos_pin[g] <= 1'b0;
               out_neg_pin[g] <= 1'b0;
               out_pos_oe[g] <= 1'b0;
               out_neg_oe[g] <= 1'b0;
               drive_strength[2*g+1:2*g] <= 2'h0;
               cml_half_swing[g] <= 1'b0;
               driver_low_power[g] <= 1'b1;
            end else if (ce) begin
               out_pos_pin[g] <= run & (pos_src ^ polarity_invert);
               drive_strength[2*g+1:2*g] <= cfg2_r[g][OCDP_B_DRV+1:OCDP_B_DRV];
               cml_half_swing[g] <= fmt == OCDP_F_CML_HALF;
               driver_low_power[g] <= fmt == OCDP_F_OFF;
               out_pos_oe[g] <= fmt != OCDP_F_OFF && fmt <= OCDP_F_CMOS_INV;
               out_neg_oe[g] <= fmt != OCDP_F_OFF && fmt != OCDP_F_CMOS_P
                                && fmt <= OCDP_F_CMOS_INV;
               case (fmt)
                  OCDP_F_CMOS_SAME: out_neg_pin[g] <= run & (neg_src ^ polarity_invert);
                  OCDP_F_CMOS_INV: begin
                     out_neg_pin[g] <= run & (cfg2_r[g][OCDP_B_NLD] ? (neg_src ^ polarity_invert)
                                                                   : ~(neg_src ^ polarity_invert));
                  end
                  OCDP_F_CMOS_P: out_neg_pin[g] <= 1'b0;
                  default: out_neg_pin[g] <= run & ~(pos_src ^ polarity_invert);
               endcase
            end
         end

         // A disabled format leaves both pins undriven.
         property p_off_hiz;
            @(posedge clk) disable iff (srst)
            ce && fmt == OCDP_F_OFF |=> !out_pos_oe[g] && !out_neg_oe[g] && driver_low_power[g];
         endproperty
         a_off_hiz: assert property (p_off_hiz) else $error("disabled output still driven");
         // Without divider enable the positive pin stays low.
         property p_no_run;
            @(posedge clk) disable iff (srst)
            ce && !div_en_r[g] |=> !out_pos_pin[g];
         endproperty
         a_no_run: assert property (p_no_run) else $error("output toggles while disabled");
         // With m at 3 and no shift pending, the mid high level holds for exactly its four-cycle phase length.
         property p_mid_half;
            @(posedge clk) disable iff (srst || !ce)
            run && m == 7'h03 && extra_r == 9'sd0 && !pend_r[g] && $rose(mid_r)
            |-> mid_r [*4] ##1 !mid_r;
         endproperty
         a_mid_half: assert property (p_mid_half) else $error("mid high time wrong");
         // A bypassed mid divider toggles every cycle.
         property p_bypass;
            @(posedge clk) disable iff (srst || !ce || !run)
            m == 7'h00 ##1 m == 7'h00 |-> mid_r != $past(mid_r);
         endproperty
         a_bypass: assert property (p_bypass) else $error("bypass not toggling");
         // The shift amount never leaves the allowed window.
         property p_clamp;
            @(posedge clk) disable iff (srst)
            extra_r != 9'sd0 |-> extra_r >= neg_lim && extra_r <= pos_lim;
         endproperty
         a_clamp: assert property (p_clamp) else $error("phase shift beyond limit");
         // A shift is applied for one high time only and then cleared.
         property p_one_period;
            @(posedge clk) disable iff (srst || !ce)
            $fell(mid_r) |-> extra_r == 9'sd0;
         endproperty
         a_one_period: assert property (p_one_period) else $error("shift kept past one period");
      end
   endgenerate

   // Phase reset always clears an armed state on the next edge.
   property p_cancel;
      @(posedge clk) disable iff (srst)
      ce && prst_pulse && state_r == OCDP_ARMED |=> state_r == OCDP_IDLE;
   endproperty
   a_cancel: assert property (p_cancel) else $error("armed state not cancelled");
   // Busy is only entered through a trigger while armed.
   property p_busy_cause;
      @(posedge clk) disable iff (srst)
      ce && state_r != OCDP_BUSY ##1 state_r == OCDP_BUSY |-> $past(trg_take);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without trigger");
   // Status read reflects the machine state on the next cycle.
   property p_status;
      @(posedge clk) disable iff (srst)
      ce && addr_ok && !hwrite && haddr == {24'h00_0000, OCDP_A_PH_STATUS}
      |=> hrdata[1:0] == {$past(state_r == OCDP_BUSY), $past(state_r == OCDP_ARMED)};
   endproperty
   a_status: assert property (p_status) else $error("phase status mismatch");
endmodule

// >>> verif/ocdp_clk_rx.sv
// Clock receiver model that measures the high and low run lengths of one output pin.
`timescale 1ns/1ps
module ocdp_clk_rx (
   input wire logic clk,
   input wire logic srst,
   input wire logic din,
   output logic [15:0] hi_len,
   output logic [15:0] lo_len
);
   logic [15:0] run_r;
   logic din_r;
   // Counts each level run and stores its length when the level flips.
   always_ff @(posedge clk) begin
      if (srst) begin
         run_r <= 16'h0001;
         din_r <= 1'b0;
         hi_len <= 16'h0000;
         lo_len <= 16'h0000;
      end else begin
         din_r <= din;
         if (din !== din_r) begin
            run_r <= 16'h0001;
            if (din_r) begin
               hi_len <= run_r;
            end else begin
               lo_len <= run_r;
            end
         end else begin
            run_r <= run_r + 16'h0001;
         end
      end
   end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the output clock path.
`timescale 1ns/1ps
module tb;
   import ocdp_pkg::*;
   logic clk, srst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [3:0] gp_pin;
   logic [2:0] pos, pos_oe, neg, neg_oe, half, lowp;
   logic [5:0] drv;
   logic [15:0] ph, pl, nh, nl;
   int num_errors = 0;
   int checks_done = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Design and two receivers on output 0.
   ocdp_top dut_u (.clk(clk), .srst(srst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .gp_pin(gp_pin),
      .out_pos_pin(pos), .out_pos_oe(pos_oe), .out_neg_pin(neg), .out_neg_oe(neg_oe),
      .drive_strength(drv), .cml_half_swing(half), .driver_low_power(lowp));
   ocdp_clk_rx pos_rx (.clk(clk), .srst(srst), .din(pos[0]), .hi_len(ph), .lo_len(pl));
   ocdp_clk_rx neg_rx (.clk(clk), .srst(srst), .din(neg[0]), .hi_len(nh), .lo_len(nl));
   ////////////////////////////////////////////////////////////////////////////////
   // One AHB-Lite single word transfer; read data lands in rd.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h00000000);
      check(what, rd, exp);
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Watches the positive pin for one high time lengthened by the phase step.
   task automatic watch_long();
      logic seen;
      seen = 1'b0;
      repeat (40) begin
         @(posedge clk);
         if (ph === 16'h0006) seen = 1'b1;
      end
      check("long high", 32'(seen), 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("low power", 32'(lowp), 32'h7);
      check("pos oe", 32'(pos_oe), 32'h0);
      check("resp", 32'(hresp), 32'h0);
      chk_rd("arm source", OCDP_A_PH_CTRL_B, 32'h1);
      chk_rd("status", OCDP_A_PH_STATUS, 32'h0);
      chk_rd("unmapped", 8'h40, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_div();
      wr(OCDP_A_OUT_BASE, 32'h3);
      wr(8'h14, 32'h1);
      pause(40);
      check("gated", 32'(ph), 32'h0);
      wr(OCDP_A_DIV_EN, 32'h1);
      pause(40);
      check("mid hi", 32'(ph), 32'h4);
      check("mid lo", 32'(pl), 32'h4);
      wr(OCDP_A_OUT_BASE, 32'h4);
      pause(40);
      check("odd hi", 32'(ph), 32'h5);
      check("odd lo", 32'(pl), 32'h5);
      wr(OCDP_A_OUT_BASE, 32'h1);
      wr(8'h18, 32'h2);
      wr(8'h14, 32'h101);
      pause(60);
      check("low hi", 32'(ph), 32'h6);
      wr(8'h1C, 32'h1);
      pause(60);
      check("pulse hi", 32'(ph), 32'h4);
      check("pulse lo", 32'(pl), 32'h8);
      wr(8'h14, 32'h111);
      pause(60);
      check("inv hi", 32'(ph), 32'h8);
      check("inv lo", 32'(pl), 32'h4);
      wr(OCDP_A_OUT_BASE, 32'h5);
      wr(8'h14, 32'h205);
      pause(120);
      check("dual p hi", 32'(ph), 32'h6);
      check("dual p lo", 32'(pl), 32'h6);
      check("dual n hi", 32'(nh), 32'hC);
      check("dual n lo", 32'(nl), 32'h18);
      wr(OCDP_A_OUT_BASE, 32'h0);
      wr(8'h14, 32'h1);
      wr(8'h1C, 32'h0);
      pause(20);
      check("bypass", 32'(ph), 32'h1);
      $display("test dividers done");
   endtask
   task automatic t_format();
      logic [6:0] po, no, hf, lp;
      po = 7'b1111110;
      no = 7'b1101110;
      hf = 7'b0000100;
      lp = 7'b0000001;
      for (int f = 0; f < 7; f++) begin
         wr(8'h14, 32'h40 | 32'(f));
         pause(4);
         check("pos oe", 32'(pos_oe[0]), 32'(po[f]));
         check("neg oe", 32'(neg_oe[0]), 32'(no[f]));
         check("half", 32'(half[0]), 32'(hf[f]));
         check("low power", 32'(lowp[0]), 32'(lp[f]));
         check("drive", 32'(drv[1:0]), 32'h2);
      end
      $display("test formats done");
   endtask
   task automatic t_phase();
      wr(8'h14, 32'h1);
      wr(OCDP_A_OUT_BASE, 32'h83);
      wr(8'h1C, 32'h200);
      wr(OCDP_A_PH_CTRL_B, 32'h1);
      wr(OCDP_A_PH_CTRL_A, 32'h11);
      wr(OCDP_A_PH_CTRL_A, 32'h3);
      chk_rd("armed", OCDP_A_PH_STATUS, 32'h1);
      wr(OCDP_A_PH_CTRL_A, 32'h11);
      chk_rd("cancel", OCDP_A_PH_STATUS, 32'h0);
      wr(OCDP_A_PH_CTRL_A, 32'h1);
      wr(OCDP_A_PH_CTRL_A, 32'h3);
      wr(OCDP_A_PH_CTRL_A, 32'h7);
      watch_long();
      chk_rd("done", OCDP_A_PH_STATUS, 32'h0);
      pause(20);
      check("one period", 32'(ph), 32'h4);
      wr(OCDP_A_PH_CTRL_B, 32'h12);
      wr(OCDP_A_PH_CTRL_A, 32'h19);
      gp_pin <= 4'h1;
      pause(8);
      chk_rd("pin armed", OCDP_A_PH_STATUS, 32'h1);
      gp_pin <= 4'h0;
      watch_long();
      chk_rd("pin fired", OCDP_A_PH_STATUS, 32'h0);
      $display("test phase done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Free running clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Cuts a hang short well after the tests should have ended.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("timeout reached");
      close_out();
   end
   // Reset, then the scenarios in turn.
   initial begin
      srst <= 1'b1;
      hsel <= 1'b0;
      haddr <= 32'h0;
      htrans <= 2'b00;
      hwrite <= 1'b0;
      hwdata <= 32'h0;
      gp_pin <= 4'h0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_div();
      t_format();
      t_phase();
      close_out();
   end
endmodule
